// file: cpw_channel.sv
/*
 * Pulse-width channel with its AXI4-Lite register slave.
 * Assumes a single 10 MHz clock, a synchronous active-low reset and a
 * sleep request that comes from logic on the same clock.
 */
`timescale 1ns/10ps
`include "cpw_defs.svh"

// Operation
// - Period is (limit+1) times four clocks times prescale
// - Match: clear count, set pin unless duty is zero, load duty
// - Postscaler never affects output period
// - Duty writes apply only after next match
// - Alignment bit selects left or right placement
// - Byte layout of duty follows alignment
// - Time base is count plus two bits
// - Clear pin when time base equals duty
// - Duty above period leaves pin unchanged
// - Resolution grows with period limit, max ten
// - Sleep freezes timer and holds pin level
// - Reset restores registers, pin becomes input
// - Pin driven only when direction selects output
// - Control bit 7 enables channel
// - Control bit 5 reads output level
// - Mode 11xx is pulse-width, 0000 off
module cpw_channel (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System
    input wire logic sleep_mode,
    // Output pin
    output logic channel_output_pin,
    output logic channel_output_oe_n
);
    import cpw_pkg::*;

    // Registers
    logic [7:0] pw_lo_ff;
    logic [7:0] pw_hi_ff;
    logic en_ff;
    logic fmt_ff;
    logic [3:0] mode_ff;
    logic [7:0] period_limit_ff;
    logic tmr_on_ff;
    logic [1:0] tmr_src_ff;
    logic [1:0] timer_prescale_select_ff;
    logic match_flag_ff;
    logic pin_direction_ff;

    // Channel state
    logic [9:0] duty_buf_ff;
    logic out_ff;

    // Bus state
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Decode and timer wiring
    logic wr_go;
    logic rd_go;
    cpw_reg_e wr_sel;
    cpw_reg_e rd_sel;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic pwm_on;
    logic [9:0] duty_now;
    cpw_tmr_cfg_s tmr_cfg;
    cpw_tmr_sts_s tmr_sts;
    logic [7:0] ctl_rd;
    logic [7:0] tctl_rd;
    logic [7:0] nxt_rbyte;

    // Register select from a word address
    function automatic cpw_reg_e decode(input logic [11:0] addr);
        if (addr[11:2] == `CPW_IDX_PW_LO) begin
            decode = CPW_R_PW_LO;
        end else if (addr[11:2] == `CPW_IDX_PW_HI) begin
            decode = CPW_R_PW_HI;
        end else if (addr[11:2] == `CPW_IDX_CTL) begin
            decode = CPW_R_CTL;
        end else if (addr[11:2] == `CPW_IDX_PRD) begin
            decode = CPW_R_PRD;
        end else if (addr[11:2] == `CPW_IDX_TCTL) begin
            decode = CPW_R_TCTL;
        end else if (addr[11:2] == `CPW_IDX_TCNT) begin
            decode = CPW_R_TCNT;
        end else if (addr[11:2] == `CPW_IDX_STAT) begin
            decode = CPW_R_STAT;
        end else if (addr[11:2] == `CPW_IDX_DIR) begin
            decode = CPW_R_DIR;
        end else begin
            decode = CPW_R_NONE;
        end
    endfunction

    // Ten-bit duty from the two bytes under the chosen alignment
    function automatic logic [9:0] align(input logic left,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
        if (left) begin
            align = {hi, lo[7:6]};
        end else begin
            align = {hi[1:0], lo};
        end
    endfunction

    // Write address and data are taken together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign s_axi_arready = rd_go;
    assign wr_sel = decode(s_axi_awaddr);
    assign rd_sel = decode(s_axi_araddr);
    assign wr_lane0 = wr_go && s_axi_wstrb[0];
    assign wbyte = s_axi_wdata[7:0];

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Duty bytes are accepted at any time; only the buffer drives the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pw_lo_ff <= `CPW_RST_PW;
            pw_hi_ff <= `CPW_RST_PW;
        end else if (wr_lane0) begin
            if (wr_sel == CPW_R_PW_LO) begin
                pw_lo_ff <= wbyte;
            end else if (wr_sel == CPW_R_PW_HI) begin
                pw_hi_ff <= wbyte;
            end
        end
    end

    // Control: bit 6 unimplemented and bit 5 read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_ff <= 1'(`CPW_RST_CTL >> `CPW_CTL_EN);
            fmt_ff <= 1'b0;
            mode_ff <= 4'h0;
        end else if (wr_lane0 && wr_sel == CPW_R_CTL) begin
            en_ff <= wbyte[`CPW_CTL_EN];
            fmt_ff <= wbyte[`CPW_CTL_FMT];
            mode_ff <= wbyte[`CPW_CTL_MODE_HI:`CPW_CTL_MODE_LO];
        end
    end

    // Period timer configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_limit_ff <= `CPW_RST_PRD;
            tmr_on_ff <= 1'b0;
            tmr_src_ff <= 2'h0;
            timer_prescale_select_ff <= 2'h0;
        end else if (wr_lane0) begin
            if (wr_sel == CPW_R_PRD) begin
                period_limit_ff <= wbyte;
            end else if (wr_sel == CPW_R_TCTL) begin
                tmr_on_ff <= wbyte[`CPW_TCTL_ON];
                tmr_src_ff <= wbyte[`CPW_TCTL_SRC_HI:`CPW_TCTL_SRC_LO];
                timer_prescale_select_ff <= wbyte[`CPW_TCTL_TIMER_PRESCALE_SELECT_HI:`CPW_TCTL_TIMER_PRESCALE_SELECT_LO];
            end
        end
    end

    // Match flag: write one to clear, a match in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_flag_ff <= 1'b0;
        end else if (tmr_sts.period_match) begin
            match_flag_ff <= 1'b1;
        end else if (wr_lane0 && wr_sel == CPW_R_STAT && wbyte[0]) begin
            match_flag_ff <= 1'b0;
        end
    end

    // Direction resets to input so the pin floats until software opens it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_direction_ff <= `CPW_RST_DIR;
        end else if (wr_lane0 && wr_sel == CPW_R_DIR) begin
            pin_direction_ff <= wbyte[0];
        end
    end

    assign tmr_cfg.on = tmr_on_ff;
    assign tmr_cfg.src = tmr_src_ff;
    assign tmr_cfg.timer_prescale_select = timer_prescale_select_ff;
    assign tmr_cfg.period_limit = period_limit_ff;

    cpw_period_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(tmr_cfg),
        .sleep_mode(sleep_mode),
        .sts(tmr_sts)
    );

    // Alignment only matters in pulse-width mode
    assign pwm_on = en_ff &&
        (mode_ff[3:2] == `CPW_MODE_PWM_TOP);
    assign duty_now = align(fmt_ff, pw_hi_ff, pw_lo_ff);

    // Double buffer keeps a mid-period write from glitching the pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_buf_ff <= 10'h000;
        end else if (tmr_sts.period_match) begin
            duty_buf_ff <= duty_now;
        end
    end

    // Output latch. A duty the time base never reaches leaves the
    // level alone, giving a full-high period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_ff <= 1'b0;
        end else if (!pwm_on) begin
            out_ff <= 1'b0;
        end else if (tmr_sts.period_match) begin
            out_ff <= (duty_now != 10'h000);
        end else if (tmr_sts.time_base == duty_buf_ff) begin
            out_ff <= 1'b0;
        end
    end

    // Sleep freezes the time base, so the level simply holds
    assign channel_output_pin = out_ff;
    assign channel_output_oe_n = pin_direction_ff;

    // Readback images
    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[`CPW_CTL_EN] = en_ff;
        ctl_rd[`CPW_CTL_OUT] = out_ff;
        ctl_rd[`CPW_CTL_FMT] = fmt_ff;
        ctl_rd[`CPW_CTL_MODE_HI:`CPW_CTL_MODE_LO] = mode_ff;
        tctl_rd = 8'h00;
        tctl_rd[`CPW_TCTL_ON] = tmr_on_ff;
        tctl_rd[`CPW_TCTL_SRC_HI:`CPW_TCTL_SRC_LO] = tmr_src_ff;
        tctl_rd[`CPW_TCTL_TIMER_PRESCALE_SELECT_HI:`CPW_TCTL_TIMER_PRESCALE_SELECT_LO] = timer_prescale_select_ff;
    end

    always_comb begin
        case (rd_sel)
            CPW_R_PW_LO: nxt_rbyte = pw_lo_ff;
            CPW_R_PW_HI: nxt_rbyte = pw_hi_ff;
            CPW_R_CTL: nxt_rbyte = ctl_rd;
            CPW_R_PRD: nxt_rbyte = period_limit_ff;
            CPW_R_TCTL: nxt_rbyte = tctl_rd;
            CPW_R_TCNT: nxt_rbyte = tmr_sts.count;
            CPW_R_STAT: nxt_rbyte = {7'h00, match_flag_ff};
            CPW_R_DIR: nxt_rbyte = {7'h00, pin_direction_ff};
            default: nxt_rbyte = 8'h00;
        endcase
    end

    // Write response, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `CPW_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_sel == CPW_R_NONE) ?
                `CPW_RESP_SLVERR : `CPW_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read data, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `CPW_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, nxt_rbyte};
            rresp_ff <= (rd_sel == CPW_R_NONE) ?
                `CPW_RESP_SLVERR : `CPW_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule

// file: cpw_channel_checker.sv
/* Port assertions for the pulse-width channel.
   Assumes binding to cpw_channel and one clock, aclk. */
`timescale 1ns/10ps
`include "cpw_defs.svh"

module cpw_channel_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // Pin side
    input wire logic sleep_mode,
    input wire logic channel_output_pin,
    input wire logic channel_output_oe_n
);
    localparam logic [11:0] A_CTL = {`CPW_IDX_CTL, 2'h0};
    localparam logic [11:0] A_PRD = {`CPW_IDX_PRD, 2'h0};
    localparam logic [11:0] A_TCTL = {`CPW_IDX_TCTL, 2'h0};
    localparam logic [11:0] A_DIR = {`CPW_IDX_DIR, 2'h0};
    logic wr;
    logic pin_q;
    logic seen_ff;
    logic [7:0] ctl_ff;
    logic [7:0] prd_ff;
    logic [1:0] ps_ff;
    logic [17:0] gap_ff;
    logic [17:0] per;
    assign wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    assign per = (18'(prd_ff) + 18'h1) << (2 + 2 * ps_ff);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Shadow of the written setup
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_ff <= 8'h00;
            prd_ff <= 8'hff;
            ps_ff <= 2'h0;
        end else if (wr && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                A_CTL: ctl_ff <= s_axi_wdata[7:0];
                A_PRD: prd_ff <= s_axi_wdata[7:0];
                A_TCTL: ps_ff <= s_axi_wdata[1:0];
                default: ;
            endcase
        end
    end
    // A write or sleep spoils the running period, so judge the next one
    always_ff @(posedge aclk) begin
        pin_q <= channel_output_pin;
        if (!aresetn || wr || sleep_mode) begin
            seen_ff <= 1'h0;
        end else if (channel_output_pin && !pin_q) begin
            seen_ff <= 1'h1;
        end
        gap_ff <= (channel_output_pin && !pin_q) ? 18'h1 : gap_ff + 18'h1;
    end
    reset_pin_a: assert property (
        disable iff (1'h0)
        !aresetn |=> !channel_output_pin && channel_output_oe_n)
        else $error("pin not idle after reset");
    dir_drive_a: assert property (
        wr && s_axi_wstrb[0] && s_axi_awaddr == A_DIR
        |=> channel_output_oe_n == $past(s_axi_wdata[0]))
        else $error("driver enable differs from direction");
    en_off_a: assert property (
        !ctl_ff[7] |=> !channel_output_pin)
        else $error("pin high while disabled");
    mode_off_a: assert property (
        ctl_ff[3:2] != 2'h3 |=> !channel_output_pin)
        else $error("pin high outside pulse-width mode");
    period_len_a: assert property (
        channel_output_pin && !pin_q && seen_ff |-> gap_ff == per)
        else $error("wrong output period");
    sleep_hold_a: assert property (
        sleep_mode && $past(sleep_mode) |-> $stable(channel_output_pin))
        else $error("pin moved during sleep");
    bit6_zero_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == A_CTL
        |=> !s_axi_rdata[6])
        else $error("control bit 6 read as one");
    write_resp_a: assert property (wr |=> s_axi_bvalid)
        else $error("write not answered");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule

bind cpw_channel cpw_channel_checker cpw_channel_checker_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .sleep_mode, .channel_output_pin, .channel_output_oe_n);

// file: cpw_defs.svh
/*
 * Constants of the pulse-width channel: register indices, field positions,
 * reset values and timer divide figures.
 * Assumes it is included by its bare name in design, checker and bench files.
 */
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH

// Register indices; byte address is four times the index
`define CPW_IDX_PW_LO 10'h30c
`define CPW_IDX_PW_HI 10'h30d
`define CPW_IDX_CTL 10'h30e
`define CPW_IDX_PRD 10'h31c
`define CPW_IDX_TCTL 10'h31d
`define CPW_IDX_TCNT 10'h31e
`define CPW_IDX_STAT 10'h31f
`define CPW_IDX_DIR 10'h320

// Control register fields
`define CPW_CTL_EN 7
`define CPW_CTL_OUT 5
`define CPW_CTL_FMT 4
`define CPW_CTL_MODE_HI 3
`define CPW_CTL_MODE_LO 0
`define CPW_MODE_PWM_TOP 2'h3

// Timer control fields
`define CPW_TCTL_ON 7
`define CPW_TCTL_SRC_HI 3
`define CPW_TCTL_SRC_LO 2
`define CPW_TCTL_TIMER_PRESCALE_SELECT_HI 1
`define CPW_TCTL_TIMER_PRESCALE_SELECT_LO 0
`define CPW_SRC_FOSC4 2'h1

// Reset values
`define CPW_RST_CTL 8'h00
`define CPW_RST_PW 8'h00
`define CPW_RST_PRD 8'hff
`define CPW_RST_TCTL 8'h00
`define CPW_RST_DIR 1'b1

// Timer runs at the system clock divided by this
`define CPW_TMR_DIV 4

// AXI responses
`define CPW_RESP_OKAY 2'h0
`define CPW_RESP_SLVERR 2'h2

`endif

// file: cpw_period_timer.sv
/*
 * Shared 8-bit period timer with prescaler and 10-bit time base.
 * Assumes configuration comes from registers on the same clock.
 */
`timescale 1ns/10ps
`include "cpw_defs.svh"

module cpw_period_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Configuration and sleep
    input wire cpw_pkg::cpw_tmr_cfg_s cfg,
    input wire logic sleep_mode,
    // Timer state
    output cpw_pkg::cpw_tmr_sts_s sts
);
    import cpw_pkg::*;

    logic [7:0] pre_ff;
    logic [7:0] count_ff;
    logic run;
    logic tick;

    // Last prescaler value before the timer increments
    function automatic logic [7:0] pre_limit(input logic [1:0] timer_prescale_select);
        case (timer_prescale_select)
            2'h0: pre_limit = 8'h03;
            2'h1: pre_limit = 8'h0f;
            2'h2: pre_limit = 8'h3f;
            default: pre_limit = 8'hff;
        endcase
    endfunction

    // Two time-base bits below the timer count
    function automatic logic [1:0] low_bits(input logic [1:0] timer_prescale_select,
                                            input logic [7:0] pre);
        case (timer_prescale_select)
            2'h0: low_bits = pre[1:0];
            2'h1: low_bits = pre[3:2];
            2'h2: low_bits = pre[5:4];
            default: low_bits = pre[7:6];
        endcase
    endfunction

    // Only the system clock over four gives a correct period
    assign run = cfg.on && (cfg.src == `CPW_SRC_FOSC4) && !sleep_mode;
    assign tick = run && (pre_ff == pre_limit(cfg.timer_prescale_select));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_ff <= 8'h00;
        end else if (!cfg.on) begin
            pre_ff <= 8'h00;
        end else if (run) begin
            pre_ff <= tick ? 8'h00 : pre_ff + 8'h01;
        end
    end

    // No postscaler in the path: the match alone ends a period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= 8'h00;
        end else if (tick) begin
            if (count_ff == cfg.period_limit) begin
                count_ff <= 8'h00;
            end else begin
                count_ff <= count_ff + 8'h01;
            end
        end
    end

    assign sts.count = count_ff;
    assign sts.time_base = {count_ff, low_bits(cfg.timer_prescale_select, pre_ff)};
    assign sts.period_match = tick && (count_ff == cfg.period_limit);

endmodule

// file: cpw_pin_load.sv
/* Load on the channel pin: pull-down plus pulse timer.
   Assumes pin and enable change on aclk edges. */
`timescale 1ns/10ps

module cpw_pin_load (
    // Clock
    input wire logic aclk,
    // Pin from the channel
    input wire logic pin,
    input wire logic oe_n,
    // Measurements
    output logic pad,
    output logic [17:0] hi_len,
    output logic [17:0] prd_len,
    output logic [7:0] rises
);
    logic pad_q = 1'h0;
    logic [17:0] hi_cnt = 18'h0;
    logic [17:0] prd_cnt = 18'h0;
    initial rises = 8'h0;
    // Driver off: the pull-down holds the line low
    assign pad = oe_n ? 1'h0 : pin;
    always @(posedge aclk) begin
        pad_q <= pad;
        if (pad && !pad_q) begin
            prd_len <= prd_cnt;
            prd_cnt <= 18'h1;
            hi_cnt <= 18'h1;
            rises <= rises + 8'h1;
        end else begin
            prd_cnt <= prd_cnt + 18'h1;
            hi_cnt <= hi_cnt + {17'h0, pad};
        end
        if (!pad && pad_q) begin
            hi_len <= hi_cnt;
        end
    end
endmodule

// file: cpw_pkg.sv
/*
 * Types shared by the pulse-width channel and its period timer.
 * Assumes cpw_defs.svh supplies the numeric constants.
 */
package cpw_pkg;

    typedef enum logic [3:0] {
        CPW_R_PW_LO,
        CPW_R_PW_HI,
        CPW_R_CTL,
        CPW_R_PRD,
        CPW_R_TCTL,
        CPW_R_TCNT,
        CPW_R_STAT,
        CPW_R_DIR,
        CPW_R_NONE
    } cpw_reg_e;

    typedef struct packed {
        logic on;
        logic [1:0] src;
        logic [1:0] timer_prescale_select;
        logic [7:0] period_limit;
    } cpw_tmr_cfg_s;

    typedef struct packed {
        logic [7:0] count;
        logic [9:0] time_base;
        logic period_match;
    } cpw_tmr_sts_s;

endpackage

// file: test_cpw_channel.sv
/* Self-checking bench for the pulse-width channel.
   Assumes the checker is bound and the pin load models the far side. */
`timescale 1ns/10ps
`include "cpw_defs.svh"

module test_cpw_channel;
    import cpw_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic sleep_mode = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, channel_output_pin, channel_output_oe_n, pad;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    logic [17:0] hi_len, prd_len;
    logic [7:0] rises, v;
    int n_errors = 0;
    int num_checks = 0;

    always #50 aclk = ~aclk;

    cpw_channel cpw_channel_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_mode, .channel_output_pin,
        .channel_output_oe_n);
    cpw_pin_load cpw_pin_load_i (.aclk, .pin(channel_output_pin),
        .oe_n(channel_output_oe_n), .pad, .hi_len, .prd_len, .rises);

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(posedge aclk);
        while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [9:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        v = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // Driver stays off until the match flag shows a period match
    task automatic setup(input logic [7:0] pr, ctl, hi, lo, tctl);
        wr(`CPW_IDX_DIR, 8'h01);
        wr(`CPW_IDX_PRD, pr);
        wr(`CPW_IDX_CTL, ctl);
        wr(`CPW_IDX_PW_HI, hi);
        wr(`CPW_IDX_PW_LO, lo);
        wr(`CPW_IDX_STAT, 8'h01);
        wr(`CPW_IDX_TCTL, tctl);
        do rd(`CPW_IDX_STAT); while (v[0] !== 1'h1);
        wr(`CPW_IDX_DIR, 8'h00);
    endtask

    task automatic rises_wait(input int n);
        logic [7:0] s;
        s = rises;
        while (8'(rises - s) < n) @(posedge aclk);
    endtask

    task automatic t_reset;
        logic [9:0] ix [6] = '{`CPW_IDX_PW_LO, `CPW_IDX_PW_HI, `CPW_IDX_CTL,
            `CPW_IDX_PRD, `CPW_IDX_TCTL, `CPW_IDX_DIR};
        logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h01};
        foreach (ix[i]) begin
            rd(ix[i]);
            chk(v, ex[i]);
        end
        chk(channel_output_oe_n, 1'h1);
        rd(10'h000);
        chk(r, 2'h2);
        wr(10'h000, 8'h55);
        chk(r, 2'h2);
        wr(`CPW_IDX_CTL, 8'hff);
        rd(`CPW_IDX_CTL);
        chk(v, 8'h9f);
        wr(`CPW_IDX_CTL, 8'h00);
        $display("reset and control test done");
    endtask

    // Every prescale code, three-bit resolution
    task automatic t_prescale;
        for (int k = 0; k < 4; k++) begin
            setup(8'h01, 8'h8c, 8'h00, 8'h05, {6'h21, 2'(k)});
            rises_wait(3);
            chk(prd_len, 18'(8 << (2 * k)));
            chk(hi_len, 18'((5 << (2 * k)) + 1));
        end
        $display("prescale test done");
    endtask

    // Unused bits carry junk on purpose
    task automatic t_align;
        setup(8'h01, 8'h9c, 8'h01, 8'h7f, 8'h84);
        rises_wait(3);
        chk(hi_len, 18'h6);
        setup(8'h01, 8'h8c, 8'hfc, 8'h05, 8'h84);
        rises_wait(3);
        chk(hi_len, 18'h6);
        $display("alignment test done");
    endtask

    task automatic t_edges;
        logic [7:0] s;
        setup(8'h01, 8'h8c, 8'h00, 8'h00, 8'h84);
        s = rises;
        repeat (40) @(posedge aclk);
        chk(rises, s);
        wr(`CPW_IDX_PW_LO, 8'hff);
        wr(`CPW_IDX_PW_HI, 8'h03);
        repeat (20) @(posedge aclk);
        chk(pad, 1'h1);
        rd(`CPW_IDX_CTL);
        chk(v[5], 1'h1);
        for (int m = 12; m < 16; m++) begin
            wr(`CPW_IDX_CTL, {4'h8, 4'(m)});
            chk(pad, 1'h1);
        end
        wr(`CPW_IDX_CTL, 8'h80);
        @(posedge aclk);
        chk(pad, 1'h0);
        wr(`CPW_IDX_CTL, 8'h8c);
        repeat (20) @(posedge aclk);
        wr(`CPW_IDX_CTL, 8'h0c);
        @(posedge aclk);
        chk(pad, 1'h0);
        $display("duty limits test done");
    endtask

    // New duty lands mid-period; the running pulse must keep the old one
    task automatic t_buf;
        setup(8'h07, 8'h8c, 8'h00, 8'h0a, 8'h84);
        rises_wait(2);
        wr(`CPW_IDX_PW_LO, 8'h14);
        rises_wait(1);
        chk(hi_len, 18'hb);
        rises_wait(1);
        chk(hi_len, 18'h15);
        $display("double buffer test done");
    endtask

    task automatic t_sleep;
        logic [7:0] s;
        logic p;
        sleep_mode <= 1'h1;
        rd(`CPW_IDX_TCNT);
        s = v;
        p = pad;
        repeat (20) @(posedge aclk);
        rd(`CPW_IDX_TCNT);
        chk(v, s);
        chk(pad, p);
        sleep_mode <= 1'h0;
        rises_wait(2);
        chk(prd_len, 18'h20);
        wr(`CPW_IDX_DIR, 8'h01);
        chk(channel_output_oe_n, 1'h1);
        chk(pad, 1'h0);
        $display("sleep and direction test done");
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_prescale;
        t_align;
        t_edges;
        t_buf;
        t_sleep;
        results;
    end

    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        results;
    end
endmodule
